/* rtl/tpr_target.sv */
// Serial bus target and register bank of a step-down regulator
//
// Overview of operation
// - Target only, all four bus speeds
// - Start is SDA falling while SCL high
// - Acknowledge only a matching seven-bit address
// - Direction bit picks writer; receiver acknowledges
// - Stop releases bus and waits for start
// - Unmapped register reads return zero
// - Master code not acknowledged, enters high speed
// - High speed from master code acknowledge bit; stop leaves
// - Write: address, register pointer, one data byte
// - Commit at falling edge of data acknowledge
// - Reset bit restores defaults, restarts, delays writes
// - Chip enable falling edge restores defaults
// - Bus address comes from resistor selection
// - Sixteen addresses 0x40-0x4F; grounded gives 0x46
// - Low three pointer bits select the register
// - Select pin chooses primary or alternate setpoint
// - Alternate only on select variant, resets 0x64
// - Setpoints are linear eight-bit codes
// - Primary power-up value from resistor selection
// - Control bit 6 forces fixed frequency ramps
// - Software enable stops or restarts, keeps registers
// - Control bit 4 selects light-load fixed frequency
// - Ramp speed field bits 1:0, default 11b
// - Status flags latch until reset or read
// - Interface disabled while chip enable low
`timescale 1ns/1ps
`default_nettype none
module tpr_target #(
    parameter bit HAS_SELECT_PIN = 1'b1,
    parameter bit SW_ENABLE_DEFAULT = 1'b1,
    parameter int DELAY_CYCLES = (tpr_pkg::ENABLE_DELAY_NS + tpr_pkg::CLK_PERIOD_NS - 1)
                                 / tpr_pkg::CLK_PERIOD_NS
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_o,
    input wire logic chip_enable_i,
    input wire logic supply_low_i,
    input wire logic voltage_select_input_i,
    input wire logic conv_done_i,
    input wire logic conv_grounded_i,
    input wire logic [3:0] conv_addr_i,
    input wire logic [7:0] conv_code_i,
    input wire logic thermal_warn_i,
    input wire logic hiccup_i,
    input wire logic input_undervoltage_flag_i,
    output logic [7:0] voltage_code_o,
    output logic [6:0] own_addr_o,
    output logic ramp_fixed_freq_o,
    output logic forced_fixed_frequency_o,
    output logic discharge_enable_o,
    output logic hiccup_enable_o,
    output logic [1:0] ramp_speed_o,
    output logic converter_enable_o,
    output logic restart_o,
    output logic high_speed_mode_o,
    output logic writes_blocked_o
);
    import tpr_pkg::*;

    localparam int DW = $clog2(DELAY_CYCLES + 1);
    localparam logic [DW-1:0] DELAY_LOAD = DW'(DELAY_CYCLES);

    // ------------------------------------------------------------------
    // Pin synchronisation and line events
    // ------------------------------------------------------------------
    logic scl_s, sda_s, ce_s, supply_low_s, vsel_s;
    logic scl_rise, scl_fall, start_p, stop_p;

    tpr_sync #(.W(5)) u_sync (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .d_i({scl_i, sda_i, chip_enable_i, supply_low_i, voltage_select_input_i}),
        .reset_value_i(5'h1c),
        .q_o({scl_s, sda_s, ce_s, supply_low_s, vsel_s})
    );

    tpr_line_watch u_watch (
        .clock_i(clock_i),
        .rstn_i(rstn_i),
        .scl_s_i(scl_s),
        .sda_s_i(sda_s),
        .scl_rise_o(scl_rise),
        .scl_fall_o(scl_fall),
        .start_o(start_p),
        .stop_o(stop_p)
    );

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    tpr_state_e state, next_state;
    logic [3:0] cnt, next_cnt;
    logic [7:0] shift, next_shift;
    logic [7:0] tx, next_tx;
    logic [2:0] reg_ptr, next_ptr;
    logic rw, next_rw;
    logic oe, next_oe;
    logic hs, next_hs;
    logic wr_stb, rd_stb;

    logic [7:0] primary, alternate, control, status, startup_code;
    logic [3:0] addr_low;
    logic [DW-1:0] delay_cnt;
    logic ce_prev;

    // ------------------------------------------------------------------
    // Decoding
    // ------------------------------------------------------------------
    wire addr_match = (shift[7:1] == {ADDR_UPPER, addr_low});
    wire hs_code = (shift[7:3] == HS_CODE_TOP);
    wire delay_busy = (delay_cnt != '0);
    wire wr_ok = wr_stb & ~delay_busy;
    wire wr_prim = wr_ok & (reg_ptr == REG_PRIMARY);
    wire wr_alt = wr_ok & (reg_ptr == REG_ALTERNATE) & HAS_SELECT_PIN;
    wire wr_ctrl = wr_ok & (reg_ptr == REG_CONTROL);
    wire reset_req = wr_ctrl & shift[CTRL_RESET_BIT];
    wire ce_fall = ce_prev & ~ce_s;
    wire ce_rise = ~ce_prev & ce_s;
    wire soft_clear = ce_fall | ~ce_s | supply_low_s | reset_req;
    wire sw_toggle = wr_ctrl & ~shift[CTRL_RESET_BIT]
                     & (shift[CTRL_SW_ENABLE_BIT] != control[CTRL_SW_ENABLE_BIT]);
    wire stat_clear = rd_stb & (reg_ptr == REG_STATUS);
    wire [7:0] ctrl_default = CONTROL_RESET | (8'(SW_ENABLE_DEFAULT) << CTRL_SW_ENABLE_BIT);
    wire [7:0] stat_set = (8'(thermal_warn_i) << STAT_THERMAL_BIT)
                        | (8'(hiccup_i) << STAT_HICCUP_BIT)
                        | (8'(input_undervoltage_flag_i) << STAT_UNDERVOLT_BIT);
    wire [7:0] rdata = read_mux(reg_ptr, primary, alternate, control, status);

    // Unmapped pointers, and the alternate setpoint on variants without it, read zero
    function automatic logic [7:0] read_mux(input logic [2:0] p, input logic [7:0] a,
                                            input logic [7:0] b, input logic [7:0] c,
                                            input logic [7:0] s);
        logic [7:0] r;
        r = READ_ZERO;
        if (p == REG_PRIMARY) r = a;
        if (p == REG_ALTERNATE && HAS_SELECT_PIN) r = b;
        if (p == REG_CONTROL) r = c;
        if (p == REG_STATUS) r = s;
        return r;
    endfunction

    // ------------------------------------------------------------------
    // Bus protocol
    // ------------------------------------------------------------------
    // Sampling at 50 MHz leaves about three clocks of SCL high time at the top rate.
    always_comb begin
        next_state = state;
        next_cnt = cnt;
        next_shift = shift;
        next_tx = tx;
        next_ptr = reg_ptr;
        next_rw = rw;
        next_oe = oe;
        next_hs = hs;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        if (!ce_s) begin
            next_state = ST_IDLE;
            next_oe = 1'b0;
            next_hs = 1'b0;
        end else if (stop_p) begin
            next_state = ST_IDLE;
            next_oe = 1'b0;
            next_hs = 1'b0;
        end else if (start_p) begin
            next_state = ST_ADDR;
            next_cnt = '1;                     // Start's own SCL fall wraps it to 0
            next_oe = 1'b0;
        end else if (state != ST_IDLE && state != ST_SKIP) begin
            if (scl_rise) begin
                if (cnt < BIT_ACK && state != ST_READ) begin
                    next_shift = {shift[6:0], sda_s};
                end else if (cnt == BIT_ACK && state == ST_READ && sda_s) begin
                    next_state = ST_SKIP;
                end
            end else if (scl_fall) begin
                if (cnt < BIT_LAST || &cnt) begin
                    next_cnt = cnt + 4'h1;
                    if (state == ST_READ) begin
                        next_tx = {tx[6:0], 1'b0};
                        next_oe = ~tx[6];
                    end
                end else if (cnt == BIT_LAST) begin
                    next_cnt = BIT_ACK;
                    next_oe = 1'b1;
                    case (state)
                        ST_ADDR: begin
                            next_rw = shift[0];
                            if (!addr_match) begin
                                next_oe = 1'b0;
                                next_state = ST_SKIP;
                                next_hs = hs | hs_code;
                            end
                        end
                        ST_REG: next_ptr = shift[2:0];
                        ST_READ: next_oe = 1'b0;
                        default: next_oe = 1'b1;
                    endcase
                end else begin
                    next_cnt = '0;
                    next_oe = 1'b0;
                    case (state)
                        ST_ADDR: begin
                            if (rw) begin
                                next_state = ST_READ;
                                next_tx = rdata;
                                next_oe = ~rdata[7];
                                rd_stb = 1'b1;
                            end else begin
                                next_state = ST_REG;
                            end
                        end
                        ST_REG: next_state = ST_WDATA;
                        ST_WDATA: wr_stb = 1'b1;
                        ST_READ: begin
                            next_tx = rdata;
                            next_oe = ~rdata[7];
                            rd_stb = 1'b1;
                        end
                        default: next_state = ST_SKIP;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            state <= ST_IDLE;
            cnt <= '0;
            shift <= '0;
            tx <= '0;
            reg_ptr <= '0;
            rw <= 1'b0;
            oe <= 1'b0;
            hs <= 1'b0;
        end else begin
            state <= next_state;
            cnt <= next_cnt;
            shift <= next_shift;
            tx <= next_tx;
            reg_ptr <= next_ptr;
            rw <= next_rw;
            oe <= next_oe;
            hs <= next_hs;
        end
    end

    // ------------------------------------------------------------------
    // Resistor selection results
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            addr_low <= DEFAULT_ADDR_LOW;
            startup_code <= PRIMARY_FALLBACK;
        end else if (conv_done_i) begin
            addr_low <= conv_grounded_i ? DEFAULT_ADDR_LOW : conv_addr_i;
            startup_code <= conv_code_i;
        end
    end

    // ------------------------------------------------------------------
    // Register bank
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rstn_i || soft_clear) begin
            primary <= startup_code;
            alternate <= ALTERNATE_RESET;
            control <= ctrl_default;
        end else if (conv_done_i) begin
            primary <= conv_code_i;
        end else begin
            if (wr_prim) primary <= shift;
            if (wr_alt) alternate <= shift;
            if (wr_ctrl) control <= shift & ~(8'h01 << CTRL_RESET_BIT);
        end
    end

    // A flag raised in the same cycle as the clearing read stays set
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            status <= STATUS_RESET;
        end else if (soft_clear || stat_clear) begin
            status <= stat_set;
        end else begin
            status <= status | stat_set;
        end
    end

    // Writes stay locked while the start-up sequence runs again
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            delay_cnt <= '0;
            ce_prev <= 1'b0;
        end else begin
            ce_prev <= ce_s;
            if (reset_req || ce_rise) delay_cnt <= DELAY_LOAD;
            else if (delay_busy) delay_cnt <= delay_cnt - DW'(1);
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            voltage_code_o <= PRIMARY_FALLBACK;
            converter_enable_o <= 1'b0;
            restart_o <= 1'b0;
        end else begin
            voltage_code_o <= (HAS_SELECT_PIN && vsel_s) ? alternate : primary;
            converter_enable_o <= ce_s & ~supply_low_s & ~delay_busy
                                  & control[CTRL_SW_ENABLE_BIT];
            restart_o <= reset_req | sw_toggle | ce_rise;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_o = oe;
    assign own_addr_o = {ADDR_UPPER, addr_low};
    assign high_speed_mode_o = hs;
    assign writes_blocked_o = delay_busy;
    assign ramp_fixed_freq_o = control[CTRL_RAMP_FIXED_BIT];
    assign forced_fixed_frequency_o = control[CTRL_FIXED_FREQ_BIT];
    assign discharge_enable_o = control[CTRL_DISCHARGE_BIT];
    assign hiccup_enable_o = control[CTRL_HICCUP_BIT];
    assign ramp_speed_o = control[CTRL_RAMP_HI:CTRL_RAMP_LO];
endmodule
`default_nettype wire

/* rtl/tpr_pkg.sv */
// Shared constants and types of the regulator serial target and register bank
package tpr_pkg;
    // ------------------------------------------------------------------
    // Register pointers
    // ------------------------------------------------------------------
    localparam logic [2:0] REG_PRIMARY = 3'h1;
    localparam logic [2:0] REG_ALTERNATE = 3'h2;
    localparam logic [2:0] REG_CONTROL = 3'h3;
    localparam logic [2:0] REG_STATUS = 3'h5;

    // ------------------------------------------------------------------
    // Reset values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0] ALTERNATE_RESET = 8'h64;
    localparam logic [7:0] PRIMARY_FALLBACK = 8'h64;
    localparam logic [7:0] READ_ZERO = 8'h00;
    localparam int CTRL_RESET_BIT = 7;
    localparam int CTRL_RAMP_FIXED_BIT = 6;
    localparam int CTRL_SW_ENABLE_BIT = 5;
    localparam int CTRL_FIXED_FREQ_BIT = 4;
    localparam int CTRL_DISCHARGE_BIT = 3;
    localparam int CTRL_HICCUP_BIT = 2;
    localparam int CTRL_RAMP_HI = 1;
    localparam int CTRL_RAMP_LO = 0;
    // Reset value without the software enable bit, which depends on the variant
    localparam logic [7:0] CONTROL_RESET = 8'h4f;
    localparam int STAT_THERMAL_BIT = 4;
    localparam int STAT_HICCUP_BIT = 3;
    localparam int STAT_UNDERVOLT_BIT = 0;
    localparam logic [7:0] STATUS_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Serial protocol
    // ------------------------------------------------------------------
    localparam logic [2:0] ADDR_UPPER = 3'h4;
    localparam logic [3:0] DEFAULT_ADDR_LOW = 4'h6;
    localparam logic [4:0] HS_CODE_TOP = 5'h01;
    localparam logic [3:0] BIT_LAST = 4'h7;
    localparam logic [3:0] BIT_ACK = 4'h8;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 20;
    localparam int ENABLE_DELAY_NS = 1000000;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_REG,
        ST_WDATA,
        ST_READ,
        ST_SKIP
    } tpr_state_e;
endpackage

/* rtl/tpr_sync.sv */
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none
module tpr_sync #(
    parameter int W = 1
) (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic [W-1:0] d_i,
    input wire logic [W-1:0] reset_value_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] stage1;

    // Reset loads the idle pin levels so no false edge follows reset
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            stage1 <= reset_value_i;
            q_o <= reset_value_i;
        end else begin
            stage1 <= d_i;
            q_o <= stage1;
        end
    end
endmodule
`default_nettype wire

/* rtl/tpr_line_watch.sv */
// Edge, start and stop detection on synchronised bus lines
`timescale 1ns/1ps
`default_nettype none
module tpr_line_watch (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic scl_s_i,
    input wire logic sda_s_i,
    output logic scl_rise_o,
    output logic scl_fall_o,
    output logic start_o,
    output logic stop_o
);
    logic scl_prev;
    logic sda_prev;

    // Idle bus is high on both lines, so reset to high avoids a false start
    always_ff @(posedge clock_i) begin
        if (!rstn_i) begin
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            scl_prev <= scl_s_i;
            sda_prev <= sda_s_i;
        end
    end

    assign scl_rise_o = scl_s_i & ~scl_prev;
    assign scl_fall_o = ~scl_s_i & scl_prev;
    assign start_o = scl_s_i & scl_prev & sda_prev & ~sda_s_i;
    assign stop_o = scl_s_i & scl_prev & ~sda_prev & sda_s_i;
endmodule
`default_nettype wire

/* bench/tpr_target_assertions.sv */
// Concurrent checks on the ports of the regulator serial target
`timescale 1ns/1ps
`default_nettype none
module tpr_target_checker (
    input wire logic clock_i,
    input wire logic rstn_i,
    input wire logic sda_o,
    input wire logic sda_oe_o,
    input wire logic chip_enable_i,
    input wire logic conv_done_i,
    input wire logic conv_grounded_i,
    input wire logic [6:0] own_addr_o,
    input wire logic ramp_fixed_freq_o,
    input wire logic forced_fixed_frequency_o,
    input wire logic [1:0] ramp_speed_o,
    input wire logic converter_enable_o,
    input wire logic restart_o,
    input wire logic high_speed_mode_o,
    input wire logic writes_blocked_o
);
    // ------------------------------------------------------------------
    // Cycles with chip enable low, saturating so it never wraps
    // ------------------------------------------------------------------
    logic [2:0] off_cnt;
    always_ff @(posedge clock_i) begin
        if (!rstn_i || chip_enable_i) begin
            off_cnt <= 3'h0;
        end else if (off_cnt != 3'h7) begin
            off_cnt <= off_cnt + 3'h1;
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rstn_i);
    AST_OPEN_DRAIN: assert property (sda_o == 1'b0)
        else $error("data pin driven high");
    AST_QUIET_OFF: assert property (off_cnt >= 3'h4 |-> !sda_oe_o)
        else $error("bus answered while disabled");
    AST_HS_OFF: assert property (off_cnt >= 3'h4 |-> !high_speed_mode_o)
        else $error("high speed kept while disabled");
    AST_CE_DEFAULTS: assert property ($fell(chip_enable_i) |-> ##[1:5]
        (ramp_speed_o == 2'h3 && ramp_fixed_freq_o && !forced_fixed_frequency_o))
        else $error("defaults not restored");
    AST_RESTART_PULSE: assert property (restart_o |=> !restart_o)
        else $error("restart longer than one cycle");
    AST_LOCK_STOP: assert property (writes_blocked_o [*2] |-> !converter_enable_o)
        else $error("converter on during delay");
    AST_ADDR_TOP: assert property (own_addr_o[6:4] == 3'h4)
        else $error("address outside range");
    AST_GND_ADDR: assert property (conv_done_i && conv_grounded_i |-> ##[1:3]
        own_addr_o == 7'h46)
        else $error("grounded pin address wrong");
endmodule
bind tpr_target tpr_target_checker u_tpr_target_checker (
    .clock_i(clock_i), .rstn_i(rstn_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
    .chip_enable_i(chip_enable_i), .conv_done_i(conv_done_i),
    .conv_grounded_i(conv_grounded_i), .own_addr_o(own_addr_o),
    .ramp_fixed_freq_o(ramp_fixed_freq_o), .forced_fixed_frequency_o(forced_fixed_frequency_o),
    .ramp_speed_o(ramp_speed_o), .converter_enable_o(converter_enable_o),
    .restart_o(restart_o), .high_speed_mode_o(high_speed_mode_o),
    .writes_blocked_o(writes_blocked_o));
`default_nettype wire

/* bench/tpr_bus_ctrl.sv */
// Behavioural bus controller driving the serial lines of the target
`timescale 1ns/1ps
`default_nettype none
module tpr_bus_ctrl (
    input wire logic clock_i,
    input wire logic sda_i,
    output logic scl_o,
    output logic sda_o
);
    initial begin
        scl_o = 1'b1;
        sda_o = 1'b1;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask
    // Bit of 160 ns: low 5 cycles, high 3; data only moves while low
    task automatic bit_x(input logic b, output logic r);
        tick(1);
        sda_o <= b;
        tick(4);
        scl_o <= 1'b1;
        tick(2);
        r = sda_i;
        tick(1);
        scl_o <= 1'b0;
    endtask
    task automatic byte_x(input logic [7:0] d, input logic ak, output logic [7:0] q,
                          output logic ka);
        for (int i = 7; i >= 0; i--) begin
            bit_x(d[i], q[i]);
        end
        bit_x(ak, ka);
    endtask
    // Long low time first so a target acknowledge is gone before SCL rises
    task automatic start_c();
        tick(1);
        sda_o <= 1'b1;
        tick(5);
        scl_o <= 1'b1;
        tick(3);
        sda_o <= 1'b0;
        tick(3);
        scl_o <= 1'b0;
    endtask
    task automatic stop_c();
        tick(1);
        sda_o <= 1'b0;
        tick(5);
        scl_o <= 1'b1;
        tick(3);
        sda_o <= 1'b1;
        tick(3);
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d,
                      output logic [2:0] k);
        logic [7:0] q;
        start_c();
        byte_x({a, 1'b0}, 1'b1, q, k[2]);
        byte_x(p, 1'b1, q, k[1]);
        byte_x(d, 1'b1, q, k[0]);
        stop_c();
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d,
                      output logic [2:0] k);
        logic x;
        start_c();
        byte_x({a, 1'b0}, 1'b1, d, k[2]);
        byte_x(p, 1'b1, d, k[1]);
        start_c();
        byte_x({a, 1'b1}, 1'b1, d, k[0]);
        byte_x(8'hff, 1'b1, d, x);
        stop_c();
    endtask
endmodule
`default_nettype wire

/* bench/tpr_target_tb.sv */
// Self-checking bench of the regulator serial target
`timescale 1ns/1ps
`default_nettype none
module tpr_target_tb;
    import tpr_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    logic vsel = 1'b0;
    logic cdone = 1'b0;
    logic cgnd = 1'b0;
    logic [3:0] caddr = 4'h0;
    logic [7:0] ccode = 8'h00;
    logic [2:0] flg = 3'h0;
    logic scl, msda, dsda, oe, rff, fff, dis, hen, cen, rsp_p, hs, wb, ka;
    logic [1:0] rsp;
    logic [6:0] oaddr, ad;
    logic [7:0] vcode, v, w, d;
    logic [2:0] k;
    logic [7:0] um [4] = '{8'h00, 8'h04, 8'h06, 8'h07};
    int num_errors = 0;
    int compares = 0;
    int restarts = 0;
    // Open drain: released line floats high through the pull-up
    wire sda = (oe && !dsda) ? 1'b0 : msda;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (rsp_p === 1'b1) restarts <= restarts + 1;
    end
    tpr_bus_ctrl u_tpr_bus_ctrl (.clock_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(msda));
    tpr_target #(.DELAY_CYCLES(20)) u_tpr_target (
        .clock_i(clk), .rstn_i(rstn), .scl_i(scl), .sda_i(sda), .sda_o(dsda), .sda_oe_o(oe),
        .chip_enable_i(ce), .supply_low_i(1'b0), .voltage_select_input_i(vsel),
        .conv_done_i(cdone), .conv_grounded_i(cgnd), .conv_addr_i(caddr), .conv_code_i(ccode),
        .thermal_warn_i(flg[2]), .hiccup_i(flg[1]), .input_undervoltage_flag_i(flg[0]),
        .voltage_code_o(vcode), .own_addr_o(oaddr), .ramp_fixed_freq_o(rff),
        .forced_fixed_frequency_o(fff), .discharge_enable_o(dis), .hiccup_enable_o(hen),
        .ramp_speed_o(rsp), .converter_enable_o(cen), .restart_o(rsp_p),
        .high_speed_mode_o(hs), .writes_blocked_o(wb));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic unlock();
        int n;
        n = 0;
        while (wb !== 1'b0 && n < 300) begin
            idle(1);
            n++;
        end
        if (n == 300) begin
            check(8'h1, 8'h0, "lock wait timed out");
            end_sim();
        end
    endtask
    task automatic conv(input logic g, input logic [3:0] a);
        cgnd <= g;
        caddr <= a;
        cdone <= 1'b1;
        idle(1);
        cdone <= 1'b0;
        idle(4);
        ad = g ? 7'h46 : {3'h4, a};
        check({1'b0, oaddr}, {1'b0, ad}, "address");
    endtask
    task automatic wreg(input logic [7:0] p, input logic [7:0] val);
        u_tpr_bus_ctrl.wr(ad, p, val, k);
        check({5'h0, k}, 8'h00, "write acks");
        idle(4);
    endtask
    task automatic rchk(input logic [7:0] p, input logic [7:0] exp);
        u_tpr_bus_ctrl.rd(ad, p, d, k);
        check({5'h0, k}, 8'h00, "read acks");
        check(d, exp, "read data");
    endtask
    initial begin
        void'($urandom(87421));
        idle(10);
        rstn <= 1'b1;
        idle(4);
        u_tpr_bus_ctrl.stop_c();
        unlock();
        conv(1'b1, 4'h0);
        v = 8'($urandom);
        ccode <= v;
        conv(1'b0, 4'($urandom));
        check(vcode, v, "start-up code");
        $display("test conversion done");
        rchk(8'h02, ALTERNATE_RESET);
        rchk(8'h03, CONTROL_RESET | 8'h20);
        v = 8'($urandom);
        w = ~v;
        wreg(8'h01, v);
        check(vcode, v, "primary");
        wreg(8'h02, w);
        vsel <= 1'b1;
        idle(6);
        check(vcode, w, "alternate");
        vsel <= 1'b0;
        rchk(8'h02, w);
        $display("test setpoints done");
        for (int i = 0; i < 4; i++) begin
            wreg(8'h03, 8'h38 | 8'(i));
            check({6'h0, rsp}, 8'(i), "ramp speed");
            check({4'h0, rff, fff, dis, hen}, 8'h06, "control bits");
        end
        rchk(8'h03, 8'h3b);
        wreg(8'h03, 8'h4f);
        check({7'h0, cen}, 8'h00, "soft disable");
        check(8'(restarts), 8'h02, "restart pulses");
        rchk(8'h01, v);
        wreg(8'h03, 8'h6f);
        check({6'h0, cen, wb}, 8'h02, "soft enable");
        $display("test control done");
        foreach (um[i]) begin
            wreg(um[i], 8'($urandom));
            rchk(um[i], READ_ZERO);
        end
        wreg(8'h05, 8'hff);
        u_tpr_bus_ctrl.wr(ad ^ 7'h01, 8'h01, w, k);
        check({5'h0, k}, 8'h07, "foreign address");
        rchk(8'h01, v);
        flg <= 3'($urandom);
        idle(1);
        v = {3'h0, flg[2], flg[1], 2'h0, flg[0]};
        flg <= 3'h0;
        idle(20);
        rchk(8'h05, v);
        rchk(8'h05, STATUS_RESET);
        $display("test status done");
        u_tpr_bus_ctrl.start_c();
        u_tpr_bus_ctrl.byte_x({HS_CODE_TOP, 3'($urandom)}, 1'b1, d, ka);
        idle(4);
        check({7'h0, ka}, 8'h01, "master code ack");
        check({7'h0, hs}, 8'h01, "high speed entry");
        wreg(8'h01, w);
        check({7'h0, hs}, 8'h00, "high speed exit");
        check(vcode, w, "high speed write");
        $display("test high speed done");
        wreg(8'h03, 8'h80);
        check({6'h0, rsp}, 8'h03, "reset bit ramp");
        check({7'h0, wb}, 8'h01, "reset bit lock");
        unlock();
        conv(1'b0, caddr);
        wreg(8'h03, 8'h30);
        ce <= 1'b0;
        idle(8);
        check({3'h0, rsp, rff, fff, hen}, 8'h1d, "enable fall");
        u_tpr_bus_ctrl.wr(ad, 8'h01, v, k);
        check({5'h0, k}, 8'h07, "disabled bus");
        ce <= 1'b1;
        idle(4);
        $display("test reset paths done");
        end_sim();
    end
endmodule
`default_nettype wire
